// *** src/pfdm_monitor.sv ***
// Port switch fault and disconnect monitor for one powered port
`timescale 1ns/100ps
module pfdm_monitor
#(
   parameter int DIS_TIMEOUT = pfdm_pkg::DIS_TIMEOUT_US
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Port power commands from the port sequencer
   input  wire logic                 pwr_on_cmd,
   input  wire logic                 pwr_off_cmd,
   // Comparator outputs
   input  wire pfdm_pkg::pfdm_sense_t sense_in,
   // Port control, chip reset and fault flag
   output logic                      port_pwr_en_r,
   output logic                      port_off_req,
   output logic                      chip_reset_r,
   output logic                      switch_fault
);
   import pfdm_pkg::*;

   // Longest time rounds down, never below one cycle
   localparam longint DIS_CYC_RAW = (longint'(DIS_TIMEOUT) * 64'd1000) /
                                    longint'(CLK_PERIOD_NS);
   localparam int     DIS_CYC     = (DIS_CYC_RAW < 1) ? 1 : int'(DIS_CYC_RAW);

   pfdm_state_t       state_r;        // Monitor state
   pfdm_state_t       state_nxt;      // Next monitor state
   logic [HOLD_W-1:0] hold_r;         // Chip reset pulse counter
   logic [CNT_W-1:0]  fault_cnt;      // Fault persistence count
   logic              fault_exp;      // Fault persisted too long
   logic [CNT_W-1:0]  dis_cnt;        // Disconnect timer count
   logic              dis_exp;        // Disconnect timer expired
   logic              dis_run;        // Disconnect timer advancing
   logic              reset_trig;     // Any cause of a chip reset

   // Switch fault decode
   function automatic logic is_switch_fault(input pfdm_sense_t s,
                                            input logic        en);
      is_switch_fault = (s.port_on_seen && !en) || s.sense_high ||
                        s.gate_high;
   endfunction

   // Combined fault level
   assign switch_fault = is_switch_fault(sense_in, port_pwr_en_r);

   // Persistent fault or undervoltage starts a reset
   assign reset_trig = fault_exp || sense_in.supply_undervoltage_lockout;

   // Timer advances while powered with current below threshold
   assign dis_run = port_pwr_en_r && sense_in.low_current;

   // Fault persistence timer, cleared during chip reset
   pfdm_persist_timer #(
      .W     (CNT_W),
      .LIMIT (FAULT_LIMIT)
   ) u_fault_tmr (
      .clk     (clk),
      .rst     (rst),
      .run     (switch_fault),
      .clear   (chip_reset_r),
      .count_r (fault_cnt),
      .expired (fault_exp)
   );

   // Disconnect timer; a drop of run clears it to zero
   pfdm_persist_timer #(
      .W     (CNT_W),
      .LIMIT (DIS_CYC)
   ) u_dis_tmr (
      .clk     (clk),
      .rst     (rst),
      .run     (dis_run),
      .clear   (chip_reset_r),
      .count_r (dis_cnt),
      .expired (dis_exp)
   );

   // Next state of the port monitor
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         // Hold in reset until the pulse has run out
         PFDM_RESET: begin
            if (hold_r == HOLD_ONE) begin
               state_nxt = PFDM_OFF;
            end
         end
         // Port off until commanded on
         PFDM_OFF: begin
            if (pwr_on_cmd && !pwr_off_cmd) begin
               state_nxt = PFDM_ON;
            end
         end
         // Port powered until off command or disconnect
         PFDM_ON: begin
            if (pwr_off_cmd || dis_exp) begin
               state_nxt = PFDM_OFF;
            end
         end
      endcase
      // A reset cause overrides everything
      if (reset_trig) begin
         state_nxt = PFDM_RESET;
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= PFDM_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Chip reset pulse length counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_r <= HOLD_W'(RST_HOLD_CYC);
      end else if (reset_trig) begin
         hold_r <= HOLD_W'(RST_HOLD_CYC);
      end else if (hold_r != HOLD_ZERO) begin
         hold_r <= hold_r - HOLD_ONE;
      end
   end

   // Chip reset output follows the reset state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chip_reset_r <= 1'b1;
      end else begin
         chip_reset_r <= (state_nxt == PFDM_RESET);
      end
   end

   // Port power enable, off through any reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_pwr_en_r <= 1'b0;
      end else begin
         port_pwr_en_r <= (state_nxt == PFDM_ON);
      end
   end

   // One-cycle pulse when the disconnect timer turns the port off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_off_req <= 1'b0;
      end else begin
         port_off_req <= (state_r == PFDM_ON) && dis_exp && !reset_trig;
      end
   end

   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   localparam int FAULT_LIMIT_I = FAULT_LIMIT;

   // Powered, low current, then expiry and switch-off
   sequence dis_expire_s;
      port_pwr_en_r && dis_exp && !reset_trig;
   endsequence
   sequence port_dropped_s;
      !port_pwr_en_r && port_off_req;
   endsequence

   fault_decode_a: assert property (
      (sense_in.sense_high || sense_in.gate_high ||
       (sense_in.port_on_seen && !port_pwr_en_r)) |-> switch_fault)
      else $error("switch fault not flagged");

   fault_count_a: assert property (
      switch_fault && !chip_reset_r && !fault_exp |=>
      fault_cnt == $past(fault_cnt) + CNT_W'(1))
      else $error("fault timer did not advance");

   fault_reset_a: assert property (
      (fault_cnt == CNT_W'(FAULT_LIMIT_I - 1)) && switch_fault &&
      !chip_reset_r |=> ##1 chip_reset_r)
      else $error("persistent fault did not reset chip");

   fault_early_a: assert property (
      $rose(chip_reset_r) |-> $past(fault_exp) ||
      $past(sense_in.supply_undervoltage_lockout))
      else $error("chip reset without cause");

   dis_advance_a: assert property (
      dis_run && !chip_reset_r && !dis_exp |=>
      dis_cnt == $past(dis_cnt) + CNT_W'(1))
      else $error("disconnect timer did not advance");

   dis_off_a: assert property (
      dis_expire_s |=> port_dropped_s)
      else $error("port stayed on after disconnect expiry");

   dis_clear_a: assert property (
      port_pwr_en_r && !sense_in.low_current |=> dis_cnt == '0)
      else $error("disconnect timer not cleared");

   undervolt_reset_a: assert property (
      sense_in.supply_undervoltage_lockout |=>
      chip_reset_r && !port_pwr_en_r)
      else $error("undervoltage did not reset chip");

   post_reset_a: assert property (
      chip_reset_r |=> !port_pwr_en_r && dis_cnt == '0 && fault_cnt == '0)
      else $error("state not cleared by chip reset");

   reset_len_a: assert property (
      $rose(chip_reset_r) && !sense_in.supply_undervoltage_lockout &&
      !fault_exp |->
      chip_reset_r [*4])
      else $error("chip reset pulse too short");
endmodule

// *** src/pfdm_persist_timer.sv ***
// Saturating persistence timer that counts while its condition holds
`timescale 1ns/100ps
module pfdm_persist_timer #(
   parameter int W     = 32,
   parameter int LIMIT = 1801
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Control
   input  wire logic         run,
   input  wire logic         clear,
   // Status
   output logic [W-1:0]      count_r,
   output logic              expired
);
   localparam logic [W-1:0] LIMIT_W = W'(LIMIT);
   localparam logic [W-1:0] ONE_W   = W'(1);

   // Count up while run holds, saturating at the limit; clear wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_r <= '0;
      end else if (clear || !run) begin
         count_r <= '0;
      end else if (count_r < LIMIT_W) begin
         count_r <= count_r + ONE_W;
      end
   end

   // Expiry is a level while the count sits at the limit
   assign expired = (count_r == LIMIT_W);
endmodule

// *** src/pfdm_pkg.sv ***
// Shared constants and carrier types of the port fault and disconnect monitor
package pfdm_pkg;
   // Clock rate
   localparam int CLK_PERIOD_NS  = 100;
   // Switch fault must persist longer than this before a chip reset
   localparam int FAULT_TIME_NS  = 180000;
   // Least time rounds up to whole cycles
   localparam int FAULT_CYC      = (FAULT_TIME_NS + CLK_PERIOD_NS - 1) /
                                   CLK_PERIOD_NS;
   // Reset fires on the first cycle beyond the fault time
   localparam int FAULT_LIMIT    = FAULT_CYC + 1;
   // Length of the internal chip reset pulse in cycles
   localparam int RST_HOLD_CYC   = 4;
   // Default disconnect timeout in microseconds
   localparam int DIS_TIMEOUT_US = 350000;
   // Counter widths
   localparam int CNT_W          = 32;
   localparam int HOLD_W         = 3;
   localparam logic [HOLD_W-1:0] HOLD_ZERO = 3'h0;
   localparam logic [HOLD_W-1:0] HOLD_ONE  = 3'h1;

   // Analog comparator outputs, all active high
   typedef struct packed {
      logic port_on_seen;  // Port voltage says the switch conducts
      logic sense_high;    // Sense input abnormally high
      logic gate_high;     // Gate output abnormally high
      logic low_current;   // Port current under the 7.5 mA threshold
      logic supply_undervoltage_lockout; // Supply undervoltage fault
   } pfdm_sense_t;

   // Monitor state machine
   typedef enum logic [1:0] {
      PFDM_RESET,
      PFDM_OFF,
      PFDM_ON
   } pfdm_state_t;
endpackage

// *** tb/pfdm_pd_model.sv ***
// Behavioural powered device at the far end of the cable
`timescale 1ns/100ps
module pfdm_pd_model (
   // Port power as seen by the device
   input  wire logic port_en,
   // Bench choice: device draws its maintain current now
   input  wire logic draw,
   // Current comparator result seen by the monitor
   output logic      low_current
);
   // Current flows only while powered and drawing; pulses of draw
   // restart the disconnect timer, so gaps in draw shorter than the timeout keep the port alive
   assign low_current = !(port_en && draw);
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the port fault and disconnect monitor
`timescale 1ns/100ps
module tb;
   import pfdm_pkg::*;
   localparam int DIS_US  = 2;    // Short disconnect timeout for tests
   localparam int DIS_CYC = DIS_US * 1000 / CLK_PERIOD_NS; // Cycles
   logic        clk, rst;         // Clock and reset
   logic        on_c, off_c;      // Power commands
   logic        f_pos, f_sh, f_gh; // Switch fault comparators
   logic        f_uv;             // Undervoltage comparator
   logic        draw;             // Device draws current
   logic        low_c;            // Low current from device model
   logic        en, off_req;      // Port enable and off pulse
   logic        crst, sw_f;       // Chip reset and fault flag
   pfdm_sense_t sense;            // Packed comparator word
   int          n_fail = 0;       // Mismatches
   int          cmp_count = 0;    // Comparisons
   int          cyc = 0;          // Cycles for the hang limit

   assign sense = {f_pos, f_sh, f_gh, low_c, f_uv};

   pfdm_monitor #(.DIS_TIMEOUT(DIS_US)) dut (
      .clk(clk), .rst(rst), .pwr_on_cmd(on_c), .pwr_off_cmd(off_c),
      .sense_in(sense), .port_pwr_en_r(en), .port_off_req(off_req),
      .chip_reset_r(crst), .switch_fault(sw_f));
   pfdm_pd_model pd (.port_en(en), .draw(draw), .low_current(low_c));

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Compare one bit and report a difference
   task automatic chk(input logic v, input logic e);
      cmp_count++;
      if (v !== e) begin
         n_fail++;
         $display("MISMATCH at %0t: got %b expected %b", $time, v, e);
      end
   endtask

   // Let n edges pass, then sample settled outputs
   task automatic edges(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One-cycle on command, device draw chosen by d
   task automatic pwr_on(input logic d);
      @(posedge clk) begin
         on_c <= 1'b1;
         draw <= d;
      end
      @(posedge clk) on_c <= 1'b0;
      #1 chk(en, 1'b1);
   endtask

   // Reset pulse holds then releases with port off
   task automatic t_reset;
      edges(3);
      chk(crst, 1'b1);
      chk(en, 1'b0);
      edges(2);
      chk(crst, 1'b0);
      chk(off_req, 1'b0);
   endtask

   // Off command turns off and wins over on
   task automatic t_onoff;
      pwr_on(1'b1);
      // Port seen on while commanded on is no switch fault
      @(posedge clk) f_pos <= 1'b1;
      #1 chk(sw_f, 1'b0);
      @(posedge clk) begin
         on_c <= 1'b1;
         off_c <= 1'b1;
         f_pos <= 1'b0;
      end
      @(posedge clk) begin
         on_c <= 1'b0;
         off_c <= 1'b0;
      end
      #1 chk(en, 1'b0);
   endtask

   // No draw: port turns off exactly at timeout with one pulse
   task automatic t_disc;
      pwr_on(1'b0);
      edges(DIS_CYC);
      chk(en, 1'b1);
      chk(off_req, 1'b0);
      edges(1);
      chk(en, 1'b0);
      chk(off_req, 1'b1);
      edges(1);
      chk(off_req, 1'b0);
   endtask

   // One maintain pulse late in the count restarts the timer
   task automatic t_keep;
      pwr_on(1'b0);
      edges(DIS_CYC - 5);
      @(posedge clk) draw <= 1'b1;
      @(posedge clk) draw <= 1'b0;
      edges(DIS_CYC);
      chk(en, 1'b1);
      edges(1);
      chk(en, 1'b0);
   endtask

   // Fault of 180 us is tolerated, one cycle longer resets the chip
   task automatic t_fault(input logic [2:0] m);
      if (m != 3'h4) begin
         pwr_on(1'b1);
      end
      @(posedge clk) {f_pos, f_sh, f_gh} <= m;
      #1 chk(sw_f, 1'b1);
      edges(FAULT_CYC - 1);
      @(posedge clk) {f_pos, f_sh, f_gh} <= 3'h0;
      edges(2);
      chk(crst, 1'b0);
      chk(en, m != 3'h4);
      @(posedge clk) {f_pos, f_sh, f_gh} <= m;
      edges(FAULT_LIMIT);
      chk(crst, 1'b0);
      edges(1);
      chk(crst, 1'b1);
      chk(en, 1'b0);
      @(posedge clk) {f_pos, f_sh, f_gh} <= 3'h0;
      edges(8);
      chk(crst, 1'b0);
      chk(en, 1'b0);
   endtask

   // Supply dip forces a full reset of a powered port
   task automatic t_undervolt;
      pwr_on(1'b1);
      @(posedge clk) f_uv <= 1'b1;
      @(posedge clk) f_uv <= 1'b0;
      #1 chk(crst, 1'b1);
      chk(en, 1'b0);
      edges(8);
      chk(crst, 1'b0);
   endtask

   // Counts, verdict and end of run
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Hang limit well above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict;
      end
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      {on_c, off_c, f_pos, f_sh, f_gh, f_uv} = 6'h00;
      draw = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_onoff;
      t_disc;
      t_keep;
      t_fault(3'h4);
      t_fault(3'h2);
      t_fault(3'h1);
      t_undervolt;
      print_verdict;
   end
endmodule
